/* File: fsrp_host.sv */
/*
 * APB host model that stands in for the controller issuing flash
 * commands to the suspend and resume sequencer.
 * Assumes pclk from the bench and a slave that may insert waits.
 */
`timescale 1ns/1ns
`default_nettype none

module fsrp_host
    import fsrp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    // ========================================================
    // Resume-to-suspend gap: 128 us at 10 ns per cycle
    localparam int RESUME_GAP_CYC = 12800;

    // Idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // One transfer: setup, access held until pready at an edge
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;             // Released lines do not keep value
        pwdata  <= ~d;
    endtask : xfer

    // Opcode write; suspend and resume codes pass through here
    task automatic cmd(input logic [7:0] op);
        logic [31:0] r;
        logic        e;
        xfer(OFF_CMD, 1'b1, {24'h00_0000, op}, r, e);
    endtask : cmd

    // Host keeps the gap after any resume before a new suspend
    task automatic rest_after_resume;
        repeat (RESUME_GAP_CYC) @(posedge pclk);
    endtask : rest_after_resume
endmodule : fsrp_host

`default_nettype wire

/* File: fsrp_pkg.sv */
/*
 * Constants, types and helpers for the flash suspend and resume
 * sequencer, plus the work counter that paces an erase or a program.
 * Assumes a single 100 MHz clock and an active-low asynchronous reset.
 */
// Function
// R1: Parameter word reads 45_18_83_EC at 2Ch
// R2: Bit 31 zero: suspend and resume supported
// R3: Both latency unit fields read 10b (8us)
// R4: Erase suspended within 48us of request
// R5: Host waits 128us from erase resume
// R6: Program suspended within 40us of request
// R7: Host waits 128us from program resume
// R8: No new erase while erase suspended
// R9: No program in the erase-suspended sector
// R10: No read in the erase-suspended sector
// R11: No erase or program while program suspended
// R12: No read in the program-suspended page
// R13: Erase suspend 75h, erase resume 7Ah
// R14: Program suspend 85h, program resume 8Ah
// R15: Parameter bytes are fixed and read-only
// R16: Track suspends, reject prohibited operations
`timescale 1ns/1ns
`default_nettype none

package fsrp_pkg;

    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int ERS_SUSP_MAX_NS = 48000;
    localparam int PRG_SUSP_MAX_NS = 40000;
    localparam int ERS_SUSP_MAX_CYC = ERS_SUSP_MAX_NS / CLK_PERIOD_NS;
    localparam logic [15:0] PRG_SUSP_MAX_CYC =
        16'(PRG_SUSP_MAX_NS / CLK_PERIOD_NS);
    localparam int ERS_WORK_CYC_DEF = 10000;
    localparam int PRG_WORK_CYC_DEF = 3000;

    // ========================================================
    // Register offsets and status bit positions
    localparam logic [11:0] OFF_CMD   = 12'h000;
    localparam logic [11:0] OFF_ADDR  = 12'h004;
    localparam logic [11:0] OFF_STAT  = 12'h008;
    localparam logic [11:0] OFF_PARAM = 12'h02C;
    localparam int ST_ERS_BUSY = 0;
    localparam int ST_ERS_SUSP = 1;
    localparam int ST_PRG_BUSY = 2;
    localparam int ST_PRG_SUSP = 3;
    localparam int ST_REJECT   = 4;
    localparam int ST_RD_OK    = 5;
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
    localparam logic [7:0]  RST_OP   = 8'h00;

    // ========================================================
    // Suspend parameter word fields, bit 31 down to bit 0
    localparam logic       PW_SUSP_N     = 1'b0;
    localparam logic [1:0] PW_ERS_UNIT   = 2'b10;
    localparam logic [4:0] PW_ERS_LAT    = 5'b00101;
    localparam logic [3:0] PW_ERS_RES    = 4'b0001;
    localparam logic [1:0] PW_PRG_UNIT   = 2'b10;
    localparam logic [4:0] PW_PRG_LAT    = 5'b00100;
    localparam logic [3:0] PW_PRG_RES    = 4'b0001;
    localparam logic       PW_RFU        = 1'b1;
    localparam logic [3:0] PW_ERS_PROHIB = 4'b1110;
    localparam logic [3:0] PW_PRG_PROHIB = 4'b1100;
    localparam logic [31:0] PARAM_WORD = {PW_SUSP_N, PW_ERS_UNIT,
        PW_ERS_LAT, PW_ERS_RES, PW_PRG_UNIT, PW_PRG_LAT, PW_PRG_RES,
        PW_RFU, PW_ERS_PROHIB, PW_PRG_PROHIB};

    // ========================================================
    // Opcodes and region sizes
    localparam logic [7:0] OP_ERS_SUSP  = 8'h75;
    localparam logic [7:0] OP_ERS_RES   = 8'h7A;
    localparam logic [7:0] OP_PRG_SUSP  = 8'h85;
    localparam logic [7:0] OP_PRG_RES   = 8'h8A;
    localparam logic [7:0] OP_ERS_START = 8'hE0;
    localparam logic [7:0] OP_PRG_START = 8'hE1;
    localparam logic [7:0] OP_RD_CHECK  = 8'hE2;
    localparam int SECT_LSB = 18;
    localparam int PAGE_LSB = 9;

    // ========================================================
    // Operation state, Gray along idle-run-suspending-suspended
    typedef enum logic [1:0] {
        S_IDLE    = 2'b00,
        S_RUN     = 2'b01,
        S_SUSPING = 2'b11,
        S_SUSP    = 2'b10
    } fsrp_op_t;

    // True when two addresses fall in the same aligned region
    function automatic logic fsrp_same(input logic [31:0] a,
                                       input logic [31:0] b,
                                       input int          lsb);
        fsrp_same = ((a ^ b) >> lsb) == 32'h0000_0000;
    endfunction : fsrp_same

endpackage : fsrp_pkg

// ============================================================
// Work counter: counts down while run is high, pulses done at end
module fsrp_work_ctr
    import fsrp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [23:0] load_val,
    input  wire logic        run,
    output logic             done
);
    typedef struct packed {
        logic [23:0] cnt;
    } fsrp_ctr_t;

    fsrp_ctr_t ctr_q;
    fsrp_ctr_t ctr_d;

    // Next count and completion pulse
    always_comb begin
        ctr_d = ctr_q;
        done  = run && (ctr_q.cnt == 24'h00_0001);
        if (load) begin
            ctr_d.cnt = load_val;
        end else if (run && ctr_q.cnt != 24'h00_0000) begin
            ctr_d.cnt = ctr_q.cnt - 24'h00_0001;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctr_q <= '0;
        end else begin
            ctr_q <= ctr_d;
        end
    end
endmodule : fsrp_work_ctr

`default_nettype wire

/* File: fsrp_top.sv */
/*
 * Flash suspend and resume sequencer with an APB register slave.
 * Tracks erase and program progress, suspend and resume, and
 * refuses operations that the suspend restrictions forbid.
 * Assumes the APB master on the same 100 MHz clock as pclk.
 */
`timescale 1ns/1ns
`default_nettype none

module fsrp_top
    import fsrp_pkg::*;
#(
    parameter int ERS_SUSP_LAT_CYC = ERS_SUSP_MAX_CYC,
    parameter int ERS_WORK_CYC     = ERS_WORK_CYC_DEF,
    parameter int PRG_WORK_CYC     = PRG_WORK_CYC_DEF
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef struct packed {
        fsrp_op_t    ers;
        fsrp_op_t    prg;
        logic [15:0] lat;
        logic [31:0] addr;
        logic [31:0] ers_addr;
        logic [31:0] prg_addr;
        logic [7:0]  last_op;
        logic        reject;
        logic        rd_ok;
        logic [31:0] prdata;
    } fsrp_state_t;

    fsrp_state_t q;
    fsrp_state_t d;
    logic        ers_load;
    logic        prg_load;
    logic        ers_done;
    logic        prg_done;
    logic        wr;
    logic        cmd_go;
    logic        mapped;
    logic        rej_set;
    logic [7:0]  op;

    // ========================================================
    // Work pacing for the erase and the program
    fsrp_work_ctr u_ers_ctr (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (ers_load),
        .load_val (24'(ERS_WORK_CYC)),
        .run      (q.ers == S_RUN || q.ers == S_SUSPING),
        .done     (ers_done)
    );

    fsrp_work_ctr u_prg_ctr (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (prg_load),
        .load_val (24'(PRG_WORK_CYC)),
        .run      (q.prg == S_RUN || q.prg == S_SUSPING),
        .done     (prg_done)
    );

    // ========================================================
    // APB decode, zero wait states
    assign wr      = psel && penable && pwrite;
    assign cmd_go  = wr && (paddr == OFF_CMD);
    assign op      = pwdata[7:0];
    assign mapped  = paddr == OFF_CMD || paddr == OFF_ADDR ||
                     paddr == OFF_STAT || paddr == OFF_PARAM;
    assign pready  = 1'b1;
    assign prdata  = q.prdata;
    // Parameter word refuses writes [R15]
    assign pslverr = psel && penable &&
                     (!mapped || (pwrite && paddr == OFF_PARAM));

    // ========================================================
    // Next state: commands, then latency and completion
    always_comb begin
        d        = q;
        ers_load = 1'b0;
        prg_load = 1'b0;
        rej_set  = 1'b0;
        if (wr && paddr == OFF_ADDR) begin
            d.addr = pwdata;
        end
        if (cmd_go) begin
            d.last_op = op;
            case (op)
                OP_ERS_START: begin
                    // No nested erase, none under program suspend [R8][R11]
                    if (q.ers == S_IDLE && q.prg == S_IDLE) begin
                        d.ers      = S_RUN;
                        d.ers_addr = q.addr;
                        ers_load   = 1'b1;
                    end else begin
                        rej_set = 1'b1; // [R16]
                    end
                end
                OP_ERS_SUSP: begin
                    if (q.ers == S_RUN) begin // [R13]
                        d.ers = S_SUSPING;
                        d.lat = 16'(ERS_SUSP_LAT_CYC - 1); // [R4]
                    end else begin
                        rej_set = 1'b1;
                    end
                end
                OP_ERS_RES: begin
                    if (q.ers == S_SUSP && q.prg == S_IDLE) begin // [R13]
                        d.ers = S_RUN;
                    end else begin
                        rej_set = 1'b1;
                    end
                end
                OP_PRG_START: begin
                    // Program only outside the suspended sector [R9][R11]
                    if (q.prg == S_IDLE && (q.ers == S_IDLE ||
                        (q.ers == S_SUSP &&
                         !fsrp_same(q.addr, q.ers_addr, SECT_LSB)))) begin
                        d.prg      = S_RUN;
                        d.prg_addr = q.addr;
                        prg_load   = 1'b1;
                    end else begin
                        rej_set = 1'b1; // [R16]
                    end
                end
                OP_PRG_SUSP: begin
                    if (q.prg == S_RUN) begin // [R14]
                        d.prg = S_SUSPING;
                        d.lat = PRG_SUSP_MAX_CYC - 16'h0001; // [R6]
                    end else begin
                        rej_set = 1'b1;
                    end
                end
                OP_PRG_RES: begin
                    if (q.prg == S_SUSP) begin // [R14]
                        d.prg = S_RUN;
                    end else begin
                        rej_set = 1'b1;
                    end
                end
                OP_RD_CHECK: begin
                    // Reads kept out of suspended sector and page [R10][R12]
                    d.rd_ok = (q.ers == S_IDLE || (q.ers == S_SUSP &&
                        !fsrp_same(q.addr, q.ers_addr, SECT_LSB))) &&
                        (q.prg == S_IDLE || (q.prg == S_SUSP &&
                        !fsrp_same(q.addr, q.prg_addr, PAGE_LSB)));
                    rej_set = !d.rd_ok; // [R16]
                end
                default: begin
                    rej_set = 1'b1;
                end
            endcase
        end
        // Latency countdown into the suspended state [R4][R6]
        if (q.ers == S_SUSPING || q.prg == S_SUSPING) begin
            if (q.lat != 16'h0000) begin
                d.lat = q.lat - 16'h0001;
            end else if (q.ers == S_SUSPING) begin
                d.ers = S_SUSP;
            end else begin
                d.prg = S_SUSP;
            end
        end
        // Completion wins over a pending suspend
        if (ers_done) begin
            d.ers = S_IDLE;
        end
        if (prg_done) begin
            d.prg = S_IDLE;
        end
        // Sticky refusal flag, set wins over write-one clear
        d.reject = rej_set || (q.reject && !(wr && paddr == OFF_STAT &&
                                             pwdata[ST_REJECT]));
        // Read data captured in the setup cycle
        if (psel && !penable && !pwrite) begin
            case (paddr)
                OFF_CMD:   d.prdata = {24'h00_0000, q.last_op};
                OFF_ADDR:  d.prdata = q.addr;
                OFF_STAT:  d.prdata = {26'h000_0000, q.rd_ok, q.reject,
                                       q.prg == S_SUSP,
                                       q.prg == S_RUN || q.prg == S_SUSPING,
                                       q.ers == S_SUSP,
                                       q.ers == S_RUN || q.ers == S_SUSPING};
                OFF_PARAM: d.prdata = PARAM_WORD; // [R1][R2][R3][R15]
                default:   d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.ers      <= S_IDLE;
            q.prg      <= S_IDLE;
            q.addr     <= RST_ADDR;
            q.ers_addr <= RST_ADDR;
            q.prg_addr <= RST_ADDR;
            q.last_op  <= RST_OP;
        end else begin
            q <= d;
        end
    end

    // ========================================================
    // Checks
    logic [15:0] ers_wait_q;
    logic [15:0] prg_wait_q;
    logic        param_rd;
    logic        ers_start;
    logic        prg_start;

    assign param_rd  = psel && penable && !pwrite && paddr == OFF_PARAM;
    assign ers_start = cmd_go && op == OP_ERS_START;
    assign prg_start = cmd_go && op == OP_PRG_START;

    // Cycles spent waiting for each suspend to land
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ers_wait_q <= 16'h0000;
            prg_wait_q <= 16'h0000;
        end else begin
            ers_wait_q <= (q.ers == S_SUSPING) ? ers_wait_q + 16'h0001
                                               : 16'h0000;
            prg_wait_q <= (q.prg == S_SUSPING) ? prg_wait_q + 16'h0001
                                               : 16'h0000;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ers_sus_req;
        cmd_go && op == OP_ERS_SUSP && q.ers == S_RUN && !ers_done;
    endsequence
    sequence s_prg_sus_req;
        cmd_go && op == OP_PRG_SUSP && q.prg == S_RUN && !prg_done;
    endsequence

    property p_param_word;
        param_rd |-> prdata == 32'h4518_83EC;
    endproperty
    a_param_word: assert property (p_param_word) // [R1][R15]
        else $error("Parameter word read back wrong");

    property p_supported;
        param_rd |-> !prdata[31];
    endproperty
    a_supported: assert property (p_supported) // [R2]
        else $error("Suspend support bit not zero");

    property p_units;
        param_rd |-> prdata[30:29] == 2'b10 && prdata[19:18] == 2'b10;
    endproperty
    a_units: assert property (p_units) // [R3]
        else $error("Latency unit fields wrong");

    property p_ers_lat;
        ers_wait_q <= 16'(ERS_SUSP_MAX_CYC);
    endproperty
    a_ers_lat: assert property (p_ers_lat) // [R4]
        else $error("Erase suspend latency exceeded");

    property p_prg_lat;
        prg_wait_q <= PRG_SUSP_MAX_CYC;
    endproperty
    a_prg_lat: assert property (p_prg_lat) // [R6]
        else $error("Program suspend latency exceeded");

    property p_ers_sus_cmd;
        s_ers_sus_req |=> q.ers == S_SUSPING;
    endproperty
    a_ers_sus_cmd: assert property (p_ers_sus_cmd) // [R13]
        else $error("Erase suspend opcode not taken");

    property p_prg_sus_cmd;
        s_prg_sus_req |=> q.prg == S_SUSPING ##1 q.prg == S_SUSPING;
    endproperty
    a_prg_sus_cmd: assert property (p_prg_sus_cmd) // [R14]
        else $error("Program suspend opcode not taken");

    property p_no_nest;
        ers_start && q.ers == S_SUSP |=> q.reject && q.ers == S_SUSP;
    endproperty
    a_no_nest: assert property (p_no_nest) // [R8][R16]
        else $error("Nested erase accepted");

    property p_sect_prog;
        prg_start && q.ers == S_SUSP &&
            fsrp_same(q.addr, q.ers_addr, SECT_LSB)
            |=> q.prg == S_IDLE && q.reject;
    endproperty
    a_sect_prog: assert property (p_sect_prog) // [R9]
        else $error("Program in suspended sector accepted");

    property p_prg_susp_block;
        (ers_start || prg_start) && q.prg == S_SUSP
            |=> q.reject && q.prg == S_SUSP;
    endproperty
    a_prg_susp_block: assert property (p_prg_susp_block) // [R11]
        else $error("Operation accepted under program suspend");

    property p_rd_block;
        cmd_go && op == OP_RD_CHECK && ((q.ers == S_SUSP &&
            fsrp_same(q.addr, q.ers_addr, SECT_LSB)) || (q.prg == S_SUSP &&
            fsrp_same(q.addr, q.prg_addr, PAGE_LSB)))
            |=> !q.rd_ok && q.reject;
    endproperty
    a_rd_block: assert property (p_rd_block) // [R10][R12]
        else $error("Read in suspended region granted");

endmodule : fsrp_top

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the flash suspend and resume sequencer.
 * Assumes the APB host model, a shortened erase work count and a lengthened program work count.
 */
`timescale 1ns/1ns
`default_nettype none

module tb
    import fsrp_pkg::*;
;
    typedef struct {
        logic [11:0] a;
        logic        w;
        logic [31:0] d;
        logic [31:0] exp;
        logic        err;
    } fsrp_row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          err_count;
    int          cmp_count;
    int          cyc = 0;
    fsrp_row_t   rows [9];
    logic [31:0] s;
    logic        e;
    int          took;

    fsrp_top #(.ERS_SUSP_LAT_CYC(8), .ERS_WORK_CYC(400),
               .PRG_WORK_CYC(6000)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    fsrp_host host (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // ========================================================
    // Clock, cycle count and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // Compare helpers
    task automatic chk32(input string n, input logic [31:0] x,
                         input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask : chk32
    task automatic chk1(input string n, input logic x, input logic g);
        cmp_count++;
        if (g !== x) begin
            err_count++;
            $display("Error %s expected %b seen %b", n, x, g);
        end
    endtask : chk1

    // Register access shortcuts
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic ee;
        host.xfer(a, 1'b0, 32'h0000_0000, r, ee);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        ee;
        host.xfer(a, 1'b1, d, r, ee);
    endtask : wr
    // Sticky refusal flag check, then clear it
    task automatic rej(input string n, input logic x);
        rd(OFF_STAT, s);
        chk1(n, x, s[ST_REJECT]);
        wr(OFF_STAT, 32'h0000_0010);
    endtask : rej
    // Poll one status bit for a value under a cycle bound
    task automatic wait_st(input int b, input logic v, input int lim);
        int t0;
        t0 = cyc;
        do rd(OFF_STAT, s); while (s[b] !== v && cyc - t0 < lim);
        took = cyc - t0;
        chk1("stat_poll", v, s[b]);
    endtask : wait_st
    // Read-check grant at an address
    task automatic rdchk(input logic [31:0] a, input logic x);
        wr(OFF_ADDR, a);
        host.cmd(OP_RD_CHECK);
        rd(OFF_STAT, s);
        chk1("read_grant", x, s[ST_RD_OK]);
        wr(OFF_STAT, 32'h0000_0010);
    endtask : rdchk

    // ========================================================
    // Main sequence
    initial begin
        presetn   = 1'b0;
        err_count = 0;
        cmp_count = 0;
        rows = '{'{OFF_PARAM, 0, 0, 32'h4518_83EC, 0},
                 '{OFF_STAT, 0, 0, 32'h0, 0},
                 '{OFF_ADDR, 0, 0, 32'h0, 0},
                 '{OFF_ADDR, 1, 32'h5A5A_A5A5, 32'h0, 0},
                 '{OFF_ADDR, 0, 0, 32'h5A5A_A5A5, 0},
                 '{OFF_PARAM, 1, 32'hFFFF_FFFF, 32'h0, 1},
                 '{OFF_PARAM, 0, 0, 32'h4518_83EC, 0},
                 '{12'h010, 0, 0, 32'h0, 1},
                 '{12'h010, 1, 32'h1234_5678, 32'h0, 1}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            host.xfer(rows[i].a, rows[i].w, rows[i].d, s, e);
            chk1("pslverr", rows[i].err, e);
            if (!rows[i].w)
                chk32("rdata", rows[i].exp, s);
        end
        // Field decode of the parameter word
        rd(OFF_PARAM, s);
        chk1("supported", 1'b0, s[31]);
        chk32("units", 32'h0000_000A, {28'h0, s[30:29], s[19:18]});
        chk32("ers_lat_ns", 48000, (s[28:24] + 1) * 8000);
        chk32("ers_gap_us", 128, (s[23:20] + 1) * 64);
        chk32("prg_lat_ns", 40000, (s[17:13] + 1) * 8000);
        chk32("prg_gap_us", 128, (s[12:9] + 1) * 64);
        chk32("ers_prohib", 32'hE, {28'h0, s[7:4]});
        chk32("prg_prohib", 32'hC, {28'h0, s[3:0]});
        // Suspend and resume codes refused when nothing runs
        host.cmd(OP_ERS_SUSP);
        rej("idle_ers_susp", 1'b1);
        host.cmd(OP_ERS_RES);
        rej("idle_ers_res", 1'b1);
        host.cmd(OP_PRG_SUSP);
        rej("idle_prg_susp", 1'b1);
        host.cmd(OP_PRG_RES);
        rej("idle_prg_res", 1'b1);
        host.cmd(8'h3C);
        rd(OFF_CMD, s);
        chk32("last_op", 32'h0000_003C, s);
        rej("bad_opcode", 1'b1);
        // Erase, suspend, forbidden and allowed work, resume
        wr(OFF_ADDR, 32'h0004_0000);
        host.cmd(OP_ERS_START);
        host.cmd(OP_ERS_SUSP);
        wait_st(ST_ERS_SUSP, 1'b1, 4900);
        // Limit plus the bus delay of one status poll
        chk1("ers_susp_time", 1'b1, took <= 4803);
        host.cmd(OP_ERS_START);
        rej("nested_erase", 1'b1);
        wr(OFF_ADDR, 32'h0004_0200);
        host.cmd(OP_PRG_START);
        rej("prg_in_sector", 1'b1);
        rdchk(32'h0007_FFFC, 1'b0);
        rdchk(32'h0008_0000, 1'b1);
        host.cmd(OP_PRG_START);
        rej("prg_elsewhere", 1'b0);
        wait_st(ST_PRG_BUSY, 1'b0, 7000);
        host.cmd(OP_ERS_RES);
        rd(OFF_STAT, s);
        chk1("ers_resumed", 1'b0, s[ST_ERS_SUSP]);
        host.rest_after_resume();
        chk1("ers_running", 1'b1, s[ST_ERS_BUSY]);
        wait_st(ST_ERS_BUSY, 1'b0, 1000);
        // Program, suspend, forbidden and allowed work, resume
        wr(OFF_ADDR, 32'h0000_1000);
        host.cmd(OP_PRG_START);
        host.cmd(OP_PRG_SUSP);
        wait_st(ST_PRG_SUSP, 1'b1, 4100);
        // Limit plus the bus delay of one status poll
        chk1("prg_susp_time", 1'b1, took <= 4003);
        host.cmd(OP_ERS_START);
        rej("erase_in_prg_susp", 1'b1);
        host.cmd(OP_PRG_START);
        rej("nested_prg", 1'b1);
        rdchk(32'h0000_11FC, 1'b0);
        rdchk(32'h0000_1200, 1'b1);
        host.cmd(OP_PRG_RES);
        host.rest_after_resume();
        wait_st(ST_PRG_BUSY, 1'b0, 7000);
        // Reset in mid-operation
        host.cmd(OP_PRG_START);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_STAT, s);
        chk32("stat_after_reset", 32'h0, s);
        rd(OFF_PARAM, s);
        chk32("param_after_reset", 32'h4518_83EC, s);
        wrap_up();
    end
endmodule : tb

`default_nettype wire
